// ---- rtl/ascm_pkg.sv ----
// Purpose: Shared constants, types and decode functions for the audio serial clock monitor
// Assumes: Core clock of 40 MHz; eight-bit registers on an address/data port
// Notes:   Rate codes cover both the 48 kHz and the 44.1 kHz family
package ascm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ      = 40000000;
  localparam int unsigned CORE_PERIOD_NS   = 25;
  localparam int unsigned BCLK_HALF_NS     = 50;
  localparam int unsigned BCLK_HALF_CYC    = (BCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned FRAME_TIMEOUT_US = 300;
  localparam int unsigned FRAME_TIMEOUT_CYC = FRAME_TIMEOUT_US * 1000 / CORE_PERIOD_NS;
  localparam int unsigned STABLE_FRAMES    = 4;
  localparam int unsigned TOL_LO_PCT       = 102;
  localparam int unsigned TOL_HI_PCT       = 98;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASTER_RATE_RATIO = 8'h14;
  localparam logic [7:0] ADDR_CLOCK_MON_STATUS  = 8'h15;
  localparam logic [7:0] ADDR_CLOCK_SOURCE      = 8'h16;
  localparam logic [7:0] RST_MASTER_RATE_RATIO  = 8'h48;
  localparam logic [7:0] RST_CLOCK_MON_STATUS   = 8'hff;
  localparam logic [7:0] RST_CLOCK_SOURCE       = 8'h10;

  // Field positions
  localparam int unsigned POS_RATE_HI      = 7;
  localparam int unsigned POS_RATE_LO      = 4;
  localparam int unsigned POS_RATIO_HI     = 3;
  localparam int unsigned POS_RATIO_LO     = 0;
  localparam int unsigned POS_ROOT_SEL     = 7;
  localparam int unsigned POS_SPEC_MODE    = 6;
  localparam int unsigned POS_REFRATIO_HI  = 5;
  localparam int unsigned POS_REFRATIO_LO  = 3;
  localparam int unsigned POS_EDGE_INV     = 1;

  localparam logic [3:0] CODE_INVALID  = 4'hf;
  localparam logic [3:0] RATE_CODE_MAX = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        frame_done;
    logic        timeout;
    logic [15:0] period;
    logic [15:0] bclk_count;
  } ascm_meas_type;

  typedef struct packed {
    logic        root_from_refclk;
    logic        refclk_spec_mode;
    logic        pll_enable;
    logic [11:0] refclk_ratio;
    logic [19:0] rate_hz;
    logic [11:0] bit_frame_ratio;
  } ascm_clkcfg_type;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic [19:0] ascm_rate_hz(input logic [3:0] code, input logic fam441);
    logic [19:0] f48;
    logic [19:0] f44;
    f48 = 20'h0;
    f44 = 20'h0;
    unique case (code)
      4'h0: begin f48 = 20'd8000;   f44 = 20'd7350;   end
      4'h1: begin f48 = 20'd16000;  f44 = 20'd14700;  end
      4'h2: begin f48 = 20'd24000;  f44 = 20'd22050;  end
      4'h3: begin f48 = 20'd32000;  f44 = 20'd29400;  end
      4'h4: begin f48 = 20'd48000;  f44 = 20'd44100;  end
      4'h5: begin f48 = 20'd96000;  f44 = 20'd88200;  end
      4'h6: begin f48 = 20'd192000; f44 = 20'd176400; end
      4'h7: begin f48 = 20'd384000; f44 = 20'd352800; end
      4'h8: begin f48 = 20'd768000; f44 = 20'd705600; end
      default: begin f48 = 20'h0; f44 = 20'h0; end
    endcase
    return fam441 ? f44 : f48;
  endfunction : ascm_rate_hz

  function automatic logic [11:0] ascm_ratio_value(input logic [3:0] code);
    unique case (code)
      4'h0: return 12'd16;
      4'h1: return 12'd24;
      4'h2: return 12'd32;
      4'h3: return 12'd48;
      4'h4: return 12'd64;
      4'h5: return 12'd128;
      4'h7: return 12'd192;
      4'h8: return 12'd256;
      4'h9: return 12'd384;
      4'ha: return 12'd512;
      4'hb: return 12'd1024;
      4'hc: return 12'd2048;
      default: return 12'h0;
    endcase
  endfunction : ascm_ratio_value

  function automatic logic [3:0] ascm_ratio_code(input logic [15:0] count);
    logic [3:0] code;
    code = CODE_INVALID;
    for (int k = 0; k < 13; k++) begin
      if (ascm_ratio_value(4'(k)) != 12'h0 && count == {4'h0, ascm_ratio_value(4'(k))}) code = 4'(k);
    end
    return code;
  endfunction : ascm_ratio_code

  function automatic logic [3:0] ascm_rate_code(input logic [15:0] period);
    logic [3:0]  code;
    longint      lo;
    longint      hi;
    code = CODE_INVALID;
    lo   = 0;
    hi   = 0;
    for (int k = 0; k <= 8; k++) begin
      lo = longint'(CORE_CLK_HZ) * 100 / (longint'(ascm_rate_hz(4'(k), 1'b0)) * TOL_LO_PCT);
      hi = longint'(CORE_CLK_HZ) * 100 / (longint'(ascm_rate_hz(4'(k), 1'b1)) * TOL_HI_PCT);
      if (longint'(period) >= lo && longint'(period) <= hi) code = 4'(k);
    end
    return code;
  endfunction : ascm_rate_code

  function automatic logic [11:0] ascm_refclk_ratio(input logic [2:0] sel);
    unique case (sel)
      3'h0: return 12'd64;
      3'h1: return 12'd256;
      3'h2: return 12'd384;
      3'h3: return 12'd512;
      3'h4: return 12'd768;
      3'h5: return 12'd1024;
      3'h6: return 12'd1536;
      3'h7: return 12'd2304;
    endcase
  endfunction : ascm_refclk_ratio

endpackage : ascm_pkg

// ---- rtl/ascm_edge_meter.sv ----
// Purpose: Synchronise bus clock pins and measure frame period and bits per frame
// Assumes: Pins are asynchronous to core_clk and far slower than it
// Notes:   Measurements refer to the frame that ends at each frame-sync rise
`timescale 1ns/1ps
module ascm_edge_meter
  import ascm_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = FRAME_TIMEOUT_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          bclk_pin,
  input  wire logic          frame_sync_pin,
  output ascm_pkg::ascm_meas_type meas
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers and edge history
  // ----------------------------------------------------------------
  logic [1:0]  bclk_sync_ff;
  logic [1:0]  frame_sync_sync_ff;
  logic        bclk_last_ff;
  logic        frame_sync_last_ff;
  logic [15:0] period_cnt_ff;
  logic [15:0] bit_cnt_ff;
  logic        bclk_rise;
  logic        frame_sync_rise;
  logic        idle_hit;
  logic        idle_near;
  ascm_meas_type meas_ff;

  // Edge detectors read only the second stage
  assign bclk_rise  = bclk_sync_ff[1] & ~bclk_last_ff;
  assign frame_sync_rise = frame_sync_sync_ff[1] & ~frame_sync_last_ff;
  assign idle_hit   = (period_cnt_ff == 16'(TIMEOUT_CYC));
  assign idle_near  = (period_cnt_ff == 16'(TIMEOUT_CYC - 1));  // Last count before saturation
  assign meas       = meas_ff;

  // Synchronise both pins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bclk_sync_ff  <= 2'h0;
      frame_sync_sync_ff <= 2'h0;
      bclk_last_ff  <= 1'b0;
      frame_sync_last_ff <= 1'b0;
    end else begin
      bclk_sync_ff  <= {bclk_sync_ff[0], bclk_pin};
      frame_sync_sync_ff <= {frame_sync_sync_ff[0], frame_sync_pin};
      bclk_last_ff  <= bclk_sync_ff[1];
      frame_sync_last_ff <= frame_sync_sync_ff[1];
    end
  end

  // ----------------------------------------------------------------
  // Frame counters; the period counter saturates at the idle limit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_cnt_ff <= 16'h0;
      bit_cnt_ff    <= 16'h0;
    end else if (frame_sync_rise) begin
      period_cnt_ff <= 16'h1;
      bit_cnt_ff    <= {15'h0, bclk_rise};
    end else begin
      period_cnt_ff <= idle_hit ? period_cnt_ff : period_cnt_ff + 16'h1;
      bit_cnt_ff    <= (bclk_rise && bit_cnt_ff != 16'hffff) ? bit_cnt_ff + 16'h1 : bit_cnt_ff;
    end
  end

  // Publish one result per frame and a one-cycle idle pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meas_ff <= '0;
    end else begin
      meas_ff.frame_done <= frame_sync_rise;
      meas_ff.timeout    <= idle_near & ~frame_sync_rise;  // Once per idle spell
      if (frame_sync_rise) begin
        meas_ff.period     <= period_cnt_ff;
        meas_ff.bclk_count <= bit_cnt_ff;
      end
    end
  end

endmodule : ascm_edge_meter

// ---- rtl/ascm_top.sv ----
// Purpose: Audio serial interface clock configuration and bus clock monitor
// Assumes: Registers reached by an address/data port on core_clk; pins resolved outside
// Notes:   Frame generator runs from a core clock divider in master mode
`timescale 1ns/1ps

module ascm_top
  import ascm_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = FRAME_TIMEOUT_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wr_data,
  output logic      [7:0]             reg_rd_data,
  input  wire logic                   master_slave_select,
  input  wire logic                   auto_clk_disable,
  input  wire logic                   auto_pll_disable,
  input  wire logic                   rate_family_select,
  input  wire logic                   bclk_in,
  output logic                        bclk_out,
  output logic                        bclk_oe,
  input  wire logic                   frame_sync_in,
  output logic                        frame_sync_out,
  output logic                        frame_sync_oe,
  output ascm_pkg::ascm_clkcfg_type   clk_cfg
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]      rate_ratio_ff;
  logic [7:0]      clock_source_config_ff;
  logic [7:0]      status_ff;
  logic [7:0]      rd_data_ff;
  logic [3:0]      cand_rate_ff;
  logic [3:0]      cand_ratio_ff;
  logic [2:0]      match_cnt_ff;
  logic            bclk_gen_ff;
  logic            frame_sync_gen_ff;
  logic [7:0]      div_cnt_ff;
  logic [11:0]     bit_pos_ff;
  ascm_clkcfg_type cfg_ff;
  ascm_clkcfg_type nxt_cfg;
  ascm_meas_type   meas;

  logic [3:0]      programmed_frame_rate;
  logic [3:0]      programmed_bit_frame_ratio;
  logic            slave_root_source_select;
  logic            refclk_spec_mode;
  logic [2:0]      refclk_frequency_select;
  logic            framegen_edge_invert;
  logic            auto_cfg;
  logic            slave_auto;
  logic [3:0]      meas_rate;
  logic [3:0]      meas_ratio;
  logic            same_cand;
  logic            status_load;
  logic [11:0]     gen_ratio;
  logic            gen_run;
  logic            div_wrap;
  logic            active_edge;
  logic [3:0]      eff_rate_code;
  logic [3:0]      eff_ratio_code;
  logic [7:0]      rd_mux;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign programmed_frame_rate      = rate_ratio_ff[POS_RATE_HI:POS_RATE_LO];
  assign programmed_bit_frame_ratio = rate_ratio_ff[POS_RATIO_HI:POS_RATIO_LO];
  assign slave_root_source_select   = clock_source_config_ff[POS_ROOT_SEL];
  assign refclk_spec_mode           = clock_source_config_ff[POS_SPEC_MODE];
  assign refclk_frequency_select    = clock_source_config_ff[POS_REFRATIO_HI:POS_REFRATIO_LO];
  assign framegen_edge_invert       = clock_source_config_ff[POS_EDGE_INV];
  assign auto_cfg                   = ~auto_clk_disable;
  assign slave_auto                 = ~master_slave_select & auto_cfg;

  // ----------------------------------------------------------------
  // Register port: writes and registered read data
  // ----------------------------------------------------------------
  assign rd_mux = (reg_addr == ADDR_MASTER_RATE_RATIO) ? rate_ratio_ff :
                  (reg_addr == ADDR_CLOCK_MON_STATUS)  ? status_ff     :
                  (reg_addr == ADDR_CLOCK_SOURCE)      ? clock_source_config_ff    : 8'h00;
  assign reg_rd_data = rd_data_ff;

  // Writable registers; reserved bits stored as written
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_ratio_ff <= RST_MASTER_RATE_RATIO;
      clock_source_config_ff    <= RST_CLOCK_SOURCE;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_MASTER_RATE_RATIO) rate_ratio_ff <= reg_wr_data;
      if (reg_addr == ADDR_CLOCK_SOURCE) clock_source_config_ff <= reg_wr_data;
    end
  end

  // Read data held until the next read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (reg_rd_en) begin
      rd_data_ff <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Bus clock monitor
  // ----------------------------------------------------------------
  ascm_edge_meter #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_meter (
    .core_clk  (core_clk),
    .rst       (rst),
    .bclk_pin  (bclk_in),
    .frame_sync_pin (frame_sync_in),
    .meas      (meas)
  );

  // Classification of the last frame
  assign meas_rate   = ascm_rate_code(meas.period);
  assign meas_ratio  = ascm_ratio_code(meas.bclk_count);
  assign same_cand   = (meas_rate == cand_rate_ff) && (meas_ratio == cand_ratio_ff);
  assign status_load = meas.frame_done && same_cand && (match_cnt_ff == 3'(STABLE_FRAMES - 1));

  // Consecutive-frame agreement and idle fallback
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_ff     <= RST_CLOCK_MON_STATUS;
      cand_rate_ff  <= CODE_INVALID;
      cand_ratio_ff <= CODE_INVALID;
      match_cnt_ff  <= 3'h0;
    end else if (meas.timeout) begin
      status_ff    <= {CODE_INVALID, CODE_INVALID};
      match_cnt_ff <= 3'h0;
    end else if (meas.frame_done) begin
      cand_rate_ff  <= meas_rate;
      cand_ratio_ff <= meas_ratio;
      match_cnt_ff  <= (same_cand && match_cnt_ff != 3'(STABLE_FRAMES - 1)) ? match_cnt_ff + 3'h1 : 3'h0;
      if (status_load) status_ff <= {meas_rate, meas_ratio};
    end
  end

  // ----------------------------------------------------------------
  // Master frame generator
  // ----------------------------------------------------------------
  assign gen_ratio   = ascm_ratio_value(programmed_bit_frame_ratio);
  assign gen_run     = master_slave_select && (gen_ratio != 12'h0);
  assign div_wrap    = (div_cnt_ff == 8'(BCLK_HALF_CYC - 1));
  assign active_edge = div_wrap && (bclk_gen_ff != framegen_edge_invert);

  // Bit clock divider and frame-sync pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_ff   <= 8'h0;
      bclk_gen_ff  <= 1'b0;
      frame_sync_gen_ff <= 1'b0;
      bit_pos_ff   <= 12'h0;
    end else if (!gen_run) begin
      div_cnt_ff   <= 8'h0;
      bclk_gen_ff  <= 1'b0;
      frame_sync_gen_ff <= 1'b0;
      bit_pos_ff   <= 12'h0;
    end else begin
      div_cnt_ff  <= div_wrap ? 8'h0 : div_cnt_ff + 8'h1;
      bclk_gen_ff <= div_wrap ? ~bclk_gen_ff : bclk_gen_ff;
      if (active_edge) begin
        bit_pos_ff   <= (bit_pos_ff == gen_ratio - 12'h1) ? 12'h0 : bit_pos_ff + 12'h1;
        frame_sync_gen_ff <= (bit_pos_ff == gen_ratio - 12'h1);
      end
    end
  end

  assign bclk_out       = bclk_gen_ff;
  assign frame_sync_out = frame_sync_gen_ff;
  assign bclk_oe        = master_slave_select;
  assign frame_sync_oe  = master_slave_select;

  // ----------------------------------------------------------------
  // Clock configuration outputs
  // ----------------------------------------------------------------
  assign eff_rate_code  = slave_auto ? status_ff[7:4] : programmed_frame_rate;
  assign eff_ratio_code = slave_auto ? status_ff[3:0] : programmed_bit_frame_ratio;

  always_comb begin
    nxt_cfg                  = '0;
    nxt_cfg.pll_enable       = auto_cfg & ~auto_pll_disable;
    nxt_cfg.root_from_refclk = slave_auto & auto_pll_disable & slave_root_source_select;
    nxt_cfg.refclk_spec_mode = auto_cfg & refclk_spec_mode;
    nxt_cfg.refclk_ratio     = (refclk_spec_mode || nxt_cfg.root_from_refclk) ?
                               ascm_refclk_ratio(refclk_frequency_select) : 12'h0;
    nxt_cfg.rate_hz          = ascm_rate_hz(eff_rate_code, rate_family_select);
    nxt_cfg.bit_frame_ratio  = ascm_ratio_value(eff_ratio_code);
  end

  // Registered configuration outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign clk_cfg = cfg_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_idle_seen;
    meas.timeout;
  endsequence

  sequence s_stable_run;
    status_load;
  endsequence

  property p_rate_never_reserved;
    @(posedge core_clk) disable iff (rst)
      (status_ff[7:4] <= RATE_CODE_MAX) || (status_ff[7:4] == CODE_INVALID);
  endproperty
  a_rate_never_reserved: assert property (p_rate_never_reserved) else $error("reserved rate code reported");

  property p_ratio_never_reserved;
    @(posedge core_clk) disable iff (rst)
      (status_ff[3:0] != 4'hd) && (status_ff[3:0] != 4'he);
  endproperty
  a_ratio_never_reserved: assert property (p_ratio_never_reserved) else $error("reserved ratio code reported");

  property p_idle_invalid;
    @(posedge core_clk) disable iff (rst)
      s_idle_seen |=> (status_ff == 8'hff) ##1 (clk_cfg.rate_hz == 20'h0 || !slave_auto);
  endproperty
  a_idle_invalid: assert property (p_idle_invalid) else $error("status not invalid after idle");

  property p_status_only_on_event;
    @(posedge core_clk) disable iff (rst)
      $changed(status_ff) |-> $past(status_load) || $past(meas.timeout);
  endproperty
  a_status_only_on_event: assert property (p_status_only_on_event) else $error("status changed without cause");

  property p_status_load;
    @(posedge core_clk) disable iff (rst)
      s_stable_run and !meas.timeout |=> status_ff == {$past(meas_rate), $past(meas_ratio)};
  endproperty
  a_status_load: assert property (p_status_load) else $error("stable frames not reported");

  property p_root_refclk;
    @(posedge core_clk) disable iff (rst)
      (!master_slave_select && !auto_clk_disable && auto_pll_disable && clock_source_config_ff[7])
      |=> clk_cfg.root_from_refclk;
  endproperty
  a_root_refclk: assert property (p_root_refclk) else $error("root source not refclk");

  property p_refclk_ratio;
    @(posedge core_clk) disable iff (rst)
      (clock_source_config_ff[6] && clock_source_config_ff[5:3] == 3'h7) |=> clk_cfg.refclk_ratio == 12'd2304;
  endproperty
  a_refclk_ratio: assert property (p_refclk_ratio) else $error("refclk ratio decode wrong");

  property p_family_441;
    @(posedge core_clk) disable iff (rst)
      (master_slave_select && rate_family_select && rate_ratio_ff[7:4] == 4'h4) |=> clk_cfg.rate_hz == 20'd44100;
  endproperty
  a_family_441: assert property (p_family_441) else $error("family select ignored");

  property p_slave_ignores_prog;
    @(posedge core_clk) disable iff (rst)
      slave_auto && $stable(slave_auto) |=> clk_cfg.bit_frame_ratio == ascm_ratio_value($past(status_ff[3:0]));
  endproperty
  a_slave_ignores_prog: assert property (p_slave_ignores_prog) else $error("programmed ratio used in slave");

  property p_frame_sync_edge;
    @(posedge core_clk) disable iff (rst)
      gen_run && $past(gen_run) && $changed(frame_sync_gen_ff) |-> (bclk_gen_ff == framegen_edge_invert);
  endproperty
  a_frame_sync_edge: assert property (p_frame_sync_edge) else $error("frame sync on wrong bit clock edge");

  property p_pll_enable;
    @(posedge core_clk) disable iff (rst)
      (!auto_clk_disable && auto_pll_disable) |=> !clk_cfg.pll_enable;
  endproperty
  a_pll_enable: assert property (p_pll_enable) else $error("pll left enabled");

endmodule : ascm_top

// ---- tb/ascm_host_model.sv ----
// Purpose: Host side of the audio serial bus, drives bit clock and frame sync in slave mode
// Assumes: Bit clock half period set by parameter; frame sync one bit clock wide
// Notes:   Clock stops at the end of the current bit clock once run is low
`timescale 1ns/1ps
module ascm_host_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic        run,
  input  wire logic [11:0] ratio,
  output logic             bclk,
  output logic             frame_sync
);
  // Frames of ratio bit clocks, sync high in the first bit clock
  initial begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    forever begin
      wait (run && ratio != 12'h0);  // Empty frames would spin in zero time
      for (int i = 0; i < ratio && run; i++) begin
        frame_sync = (i == 0);
        #(HALF_NS) bclk = 1'b1;
        #(HALF_NS) bclk = 1'b0;
      end
      frame_sync = 1'b0;
    end
  end
endmodule : ascm_host_model

// ---- tb/ascm_top_test.sv ----
// Purpose: Self-checking bench for the clock configuration and monitor block
// Assumes: Inputs change at the falling core clock edge
// Notes:   Short frame timeout parameter keeps the run brief
`timescale 1ns/1ps
module ascm_top_test;
  import ascm_pkg::*;
  logic core_clk, rst, wr_en, rd_en, ms, auto_dis, pll_dis, fam, run, pb, pf;
  logic [7:0] addr, wdata, rdata;
  logic [11:0] ratio;
  logic bclk_out, bclk_oe, fs_out, fs_oe, h_bclk, h_fs;
  ascm_clkcfg_type cfg;
  int num_errors = 0;
  int num_checks = 0;
  int n, m;
  ascm_top #(.TIMEOUT_CYC(3000)) DUT (.core_clk(core_clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rdata), .master_slave_select(ms),
    .auto_clk_disable(auto_dis), .auto_pll_disable(pll_dis), .rate_family_select(fam),
    .bclk_in(bclk_oe ? bclk_out : h_bclk), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
    .frame_sync_in(fs_oe ? fs_out : h_fs), .frame_sync_out(fs_out), .frame_sync_oe(fs_oe), .clk_cfg(cfg));
  ascm_host_model HOST (.run(run), .ratio(ratio), .bclk(h_bclk), .frame_sync(h_fs));
  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge core_clk) wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk) {rd_en, addr} = {1'b1, a};
    @(negedge core_clk) rd_en = 1'b0;
    @(negedge core_clk);
  endtask : rd
  // Poll status under a bound; running out ends the run
  task automatic wait_sts(input logic [7:0] e);
    for (int i = 0; i < 9000 && rdata !== e; i++) rd(8'h15);
    chk(rdata, e);
    if (rdata !== e) results();
  endtask : wait_sts
  task automatic t_regs;
    rd(8'h15); chk(rdata, 8'hff);
    rd(8'h14); chk(rdata, 8'h48);
    rd(8'h16); chk(rdata, 8'h10);
    rd(8'h33); chk(rdata, 8'h00);
    wr(8'h15, 8'h00); rd(8'h15); chk(rdata, 8'hff);
  endtask : t_regs
  task automatic t_cfg;
    wr(8'h16, 8'hf8); repeat (2) @(negedge core_clk);
    chk(cfg.root_from_refclk, 1); chk(cfg.refclk_spec_mode, 1);
    chk(cfg.refclk_ratio, 2304); chk(cfg.pll_enable, 0);
    rd(8'h16); chk(rdata, 8'hf8);
    wr(8'h16, 8'h00); pll_dis = 1'b0; repeat (2) @(negedge core_clk);
    chk(cfg.root_from_refclk, 0); chk(cfg.refclk_ratio, 0); chk(cfg.pll_enable, 1);
  endtask : t_cfg
  task automatic t_slave;
    logic [11:0] rt [4] = '{12'd104, 12'd16, 12'd64, 12'd256};
    logic [7:0]  st [4] = '{8'h4f, 8'hf0, 8'hf4, 8'hf8};
    chk({bclk_oe, fs_oe}, 0);
    run = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ratio = rt[k];
      wait_sts(st[k]);
    end
    wr(8'h14, 8'h40); repeat (2) @(negedge core_clk);
    chk(cfg.bit_frame_ratio, 256);
    run = 1'b0;
    wait_sts(8'hff);
  endtask : t_slave
  // One generated frame: bit clocks per frame and bit clock level at the sync rise
  task automatic gen_frame(input logic inv);
    logic lvl;
    {pf, pb, n, m, lvl} = {1'b1, bclk_out, 64'd0, 1'b0};
    for (int i = 0; i < 2000 && m < 2; i++) begin
      @(negedge core_clk);
      if (m == 1 && bclk_out && !pb) n++;
      if (fs_out && !pf) begin
        m++;
        lvl = bclk_out;
      end
      {pb, pf} = {bclk_out, fs_out};
    end
    chk(20'(m), 2);
    chk(20'(n), 16);
    chk(lvl, inv);
  endtask : gen_frame
  task automatic t_master;
    ms = 1'b1;
    wr(8'h14, 8'h40);
    gen_frame(1'b0);
    chk({bclk_oe, fs_oe}, 3);
    chk(cfg.rate_hz, 48000); fam = 1'b1; repeat (2) @(negedge core_clk);
    chk(cfg.rate_hz, 44100);
    ms = 1'b0;
    wr(8'h16, 8'h02);
    ms = 1'b1;
    gen_frame(1'b1);
  endtask : t_master
  // Main sequence
  initial begin
    {rst, wr_en, rd_en, ms, auto_dis, pll_dis, fam, run, addr, wdata, ratio} = {8'h80, 28'h0};
    pll_dis = 1'b1;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    t_regs;
    t_cfg;
    t_slave;
    t_master;
    results;
  end
endmodule : ascm_top_test
